// file: rtl/tmw_pkg.sv
// package: register map, field positions and mode codes of the timer
package tmw_pkg;
  // register byte addresses
  localparam logic [7:0] TMW_CTRL_A_ADDR = 8'h24;
  localparam logic [7:0] TMW_CTRL_B_ADDR = 8'h28;
  localparam logic [7:0] TMW_COUNT_ADDR = 8'h2c;
  localparam logic [7:0] TMW_CMP_A_ADDR = 8'h30;
  localparam logic [7:0] TMW_CMP_B_ADDR = 8'h34;
  localparam logic [7:0] TMW_FLAGS_ADDR = 8'h38;
  localparam logic [7:0] TMW_DIR_ADDR = 8'h3c;
  // reset values
  localparam logic [7:0] TMW_CTRL_A_RST = 8'h00;
  localparam logic [7:0] TMW_BYTE_RST = 8'h00;
  // control a fields
  localparam int TMW_A_ACT_LSB = 6;
  localparam int TMW_B_ACT_LSB = 4;
  localparam logic [7:0] TMW_CTRL_A_MASK = 8'hf3;
  // control b field
  localparam int TMW_MODE_HI_BIT = 0;
  // flag bit positions
  localparam int TMW_WRAP_BIT = 0;
  localparam int TMW_MATCH_A_BIT = 1;
  // counter landmarks
  localparam logic [7:0] TMW_BOTTOM = 8'h00;
  localparam logic [7:0] TMW_MAX = 8'hff;
  // waveform modes
  localparam logic [2:0] TMW_M_NORMAL = 3'h0;
  localparam logic [2:0] TMW_M_PC_FF = 3'h1;
  localparam logic [2:0] TMW_M_CTC = 3'h2;
  localparam logic [2:0] TMW_M_FAST_FF = 3'h3;
  localparam logic [2:0] TMW_M_PC_A = 3'h5;
  localparam logic [2:0] TMW_M_FAST_A = 3'h7;
  // output actions
  localparam logic [1:0] TMW_ACT_OFF = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TMW_ACT_SET = 2'h3;
  // counting sequence classes
  typedef enum logic [1:0] {
    TMW_SEQ_UP,
    TMW_SEQ_FAST,
    TMW_SEQ_DUAL,
    TMW_SEQ_HOLD
  } tmw_seq_t;
endpackage

// file: rtl/tmw_timer.sv
// 8-bit timer with two compare channels, waveform control and apb slave
// Function
// - counting and flags only on tick enable
// - clear-on-match: flag a, clear next tick
// - nonzero action takes pin unless mode or action is reserved, direction gates drive
// - non-pwm actions: off, toggle, clear, set
// - fast pwm a: clear/set, toggle if high
// - fast pwm b: 01 reserved, clear/set
// - phase pwm a: up/down match actions
// - phase pwm b: 01 reserved, up/down
// - fast a: compare equals top, act bottom
// - phase a: compare equals top, act top
// - channel b: compare equals top, act top
// - mode field selects sequence and top
// - compare update immediate, top or bottom
// - wrap flag at max, bottom or top
// - control a bits 3,2 read zero
// - fast pwm counts bottom to top, restarts
// - phase pwm up, turn at top without holding, down
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
module tmw_timer
  import tmw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tick_enable,
  input wire logic port_data_a,
  input wire logic port_data_b,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic wrap_flag,
  output logic match_flag_a,
  output logic match_flag_b
);

  // software-visible and internal state
  logic [7:0] ctrl_a_q; // actions and low mode bits
  logic mode_hi_q; // waveform_mode_high_bit
  logic [7:0] count_value_q; // the counter
  logic count_up_q; // dual-slope direction, 1 = up
  logic [7:0] cmp_buf_q [2]; // values software wrote
  logic [7:0] cmp_act_q [2]; // values the comparator uses
  logic [1:0] dir_q; // pin direction bits
  logic [2:0] flags_q; // wrap, match a, match b
  logic block_q; // counter written, skip next compare
  logic [1:0] oc_q; // compare output levels

  // decoded controls
  logic [2:0] waveform_mode_sel;
  logic [1:0] waveform_mode_low_bits;
  logic [1:0] action [2];
  tmw_seq_t seq;
  logic [7:0] top;
  logic at_top;
  logic at_max;
  logic at_bottom;
  logic upd_evt;
  logic wrap_evt;
  logic [1:0] match;
  logic [1:0] oc_d;
  logic [1:0] connected;

  // apb decode
  logic setup;
  logic access;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_d;

  assign waveform_mode_low_bits = ctrl_a_q[1:0];
  assign waveform_mode_sel = {mode_hi_q, waveform_mode_low_bits};
  assign action[0] = ctrl_a_q[TMW_A_ACT_LSB +: 2];
  assign action[1] = ctrl_a_q[TMW_B_ACT_LSB +: 2];

  // mode decode: sequence and top source
  always_comb begin
    seq = TMW_SEQ_HOLD; // reserved modes freeze the counter
    top = TMW_MAX;
    case (waveform_mode_sel)
      TMW_M_NORMAL: seq = TMW_SEQ_UP;
      TMW_M_PC_FF: seq = TMW_SEQ_DUAL;
      TMW_M_CTC: begin
        seq = TMW_SEQ_FAST;
        top = cmp_act_q[0];
      end
      TMW_M_FAST_FF: seq = TMW_SEQ_FAST;
      TMW_M_PC_A: begin
        seq = TMW_SEQ_DUAL;
        top = cmp_act_q[0];
      end
      TMW_M_FAST_A: begin
        seq = TMW_SEQ_FAST;
        top = cmp_act_q[0];
      end
      default: seq = TMW_SEQ_HOLD;
    endcase
  end

  assign at_top = count_value_q == top;
  assign at_max = count_value_q == TMW_MAX;
  assign at_bottom = count_value_q == TMW_BOTTOM;

  // compare buffer load point per mode
  always_comb begin
    case (seq)
      TMW_SEQ_DUAL: upd_evt = tick_enable && at_top && count_up_q;
      // fast pwm loads as the count returns to bottom
      TMW_SEQ_FAST: upd_evt = tick_enable && at_top &&
        (waveform_mode_sel != TMW_M_CTC);
      default: upd_evt = 1'b0;
    endcase
  end

  // wrap flag source per mode
  always_comb begin
    case (waveform_mode_sel)
      TMW_M_NORMAL, TMW_M_CTC, TMW_M_FAST_FF: wrap_evt = at_max;
      TMW_M_PC_FF, TMW_M_PC_A: wrap_evt = at_bottom && !count_up_q;
      TMW_M_FAST_A: wrap_evt = at_top;
      default: wrap_evt = 1'b0;
    endcase
  end

  // apb handshake: answer is prepared in the setup cycle
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite && !pslverr;

  // read mux and address check
  always_comb begin
    rd_d = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      // reserved bits 3,2 are masked off
      TMW_CTRL_A_ADDR: rd_d[7:0] = ctrl_a_q & TMW_CTRL_A_MASK;
      TMW_CTRL_B_ADDR: rd_d[TMW_MODE_HI_BIT] = mode_hi_q;
      TMW_COUNT_ADDR: rd_d[7:0] = count_value_q;
      TMW_CMP_A_ADDR: rd_d[7:0] = cmp_buf_q[0];
      TMW_CMP_B_ADDR: rd_d[7:0] = cmp_buf_q[1];
      TMW_FLAGS_ADDR: rd_d[2:0] = flags_q;
      TMW_DIR_ADDR: rd_d[1:0] = dir_q;
      default: mapped = 1'b0;
    endcase
  end

  // bus answer flops: one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= TMW_CTRL_A_RST;
      mode_hi_q <= 1'b0;
      dir_q <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        TMW_CTRL_A_ADDR: ctrl_a_q <= pwdata[7:0] & TMW_CTRL_A_MASK;
        TMW_CTRL_B_ADDR: mode_hi_q <= pwdata[TMW_MODE_HI_BIT];
        TMW_DIR_ADDR: dir_q <= pwdata[1:0];
        default: ctrl_a_q <= ctrl_a_q;
      endcase
    end
  end

  // counter: moves only on tick enable, a bus write overrides
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= TMW_BOTTOM;
      count_up_q <= 1'b1;
      block_q <= 1'b0;
    end else if (wr_en && paddr == TMW_COUNT_ADDR) begin
      count_value_q <= pwdata[7:0];
      block_q <= 1'b1;
    end else if (tick_enable) begin
      block_q <= 1'b0;
      case (seq)
        // plain up count wraps from max to zero
        TMW_SEQ_UP: count_value_q <= count_value_q + 8'h01;
        TMW_SEQ_FAST: begin
          if (at_top) begin
            count_value_q <= TMW_BOTTOM;
          end else begin
            count_value_q <= count_value_q + 8'h01;
          end
        end
        TMW_SEQ_DUAL: begin
          // top is seen for exactly one tick before turning
          if (count_up_q && at_top) begin
            count_up_q <= 1'b0;
            count_value_q <= count_value_q - 8'h01;
          end else if (!count_up_q && at_bottom) begin
            count_up_q <= 1'b1;
            count_value_q <= count_value_q + 8'h01;
          end else if (count_up_q) begin
            count_value_q <= count_value_q + 8'h01;
          end else begin
            count_value_q <= count_value_q - 8'h01;
          end
        end
        default: count_value_q <= count_value_q;
      endcase
    end
  end

  // flags: hardware set beats a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_en && paddr == TMW_FLAGS_ADDR && pwdata[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
      if (tick_enable && wrap_evt) begin
        flags_q[TMW_WRAP_BIT] <= 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        if (match[i]) begin
          flags_q[TMW_MATCH_A_BIT + i] <= 1'b1;
        end
      end
    end
  end

  // per-channel compare, buffering and waveform
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      logic hi; // upper action bit
      logic eq_top; // compare value sits at top
      logic match_eff; // match that drives the pin
      logic is_a;
      assign is_a = (ch == 0);
      assign hi = action[ch][1];
      assign eq_top = (cmp_act_q[ch] == top);
      // a counter write removes the next compare
      assign match[ch] = tick_enable && !block_q && seq != TMW_SEQ_HOLD &&
        (count_value_q == cmp_act_q[ch]);
      assign match_eff = match[ch] && !(eq_top && hi && seq != TMW_SEQ_UP &&
        !(seq == TMW_SEQ_FAST && waveform_mode_sel == TMW_M_CTC));

      // reserved mode or action leaves the pin to the port
      always_comb begin
        connected[ch] = action[ch] != TMW_ACT_OFF;
        if (seq == TMW_SEQ_HOLD) begin
          connected[ch] = 1'b0;
        end else if (action[ch] == TMW_ACT_TOGGLE &&
                     (seq == TMW_SEQ_DUAL || (seq == TMW_SEQ_FAST &&
                      waveform_mode_sel != TMW_M_CTC))) begin
          connected[ch] = is_a && mode_hi_q;
        end
      end

      // next output level
      always_comb begin
        oc_d[ch] = oc_q[ch];
        if (!connected[ch] || seq == TMW_SEQ_HOLD) begin
          oc_d[ch] = oc_q[ch];
        end else if (seq == TMW_SEQ_UP || waveform_mode_sel == TMW_M_CTC) begin
          if (match[ch]) begin
            case (action[ch])
              TMW_ACT_TOGGLE: oc_d[ch] = !oc_q[ch];
              TMW_ACT_CLEAR: oc_d[ch] = 1'b0;
              TMW_ACT_SET: oc_d[ch] = 1'b1;
              default: oc_d[ch] = oc_q[ch];
            endcase
          end
        end else if (action[ch] == TMW_ACT_TOGGLE) begin
          if (match[ch]) begin
            oc_d[ch] = !oc_q[ch];
          end
        end else if (seq == TMW_SEQ_FAST) begin
          if (match_eff) begin
            oc_d[ch] = action[ch][0];
          end
          if (!is_a && eq_top && hi && tick_enable && at_top) begin
            oc_d[ch] = !action[ch][0];
          end
          // bottom level for a, also when its match is ignored
          if (tick_enable && at_top) begin
            oc_d[ch] = (is_a || !eq_top) ? !action[ch][0] : oc_d[ch];
          end
        end else begin
          // dual slope: up match clears for 10, down match sets
          if (match_eff) begin
            oc_d[ch] = count_up_q ? action[ch][0] :
              !action[ch][0];
          end
          if (eq_top && hi && tick_enable && at_top && count_up_q) begin
            oc_d[ch] = !action[ch][0];
          end
        end
      end

      // compare buffers and output level
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_buf_q[ch] <= TMW_BYTE_RST;
          cmp_act_q[ch] <= TMW_BYTE_RST;
          oc_q[ch] <= 1'b0;
        end else begin
          oc_q[ch] <= oc_d[ch];
          if (wr_en && paddr == (is_a ? TMW_CMP_A_ADDR : TMW_CMP_B_ADDR)) begin
            cmp_buf_q[ch] <= pwdata[7:0];
            // non-pwm modes use the written value at once
            if (seq == TMW_SEQ_UP || seq == TMW_SEQ_HOLD ||
                waveform_mode_sel == TMW_M_CTC) begin
              cmp_act_q[ch] <= pwdata[7:0];
            end
          end else if (upd_evt) begin
            cmp_act_q[ch] <= cmp_buf_q[ch];
          end
        end
      end
    end
  endgenerate

  // pin drivers: direction bit gates the driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_out <= 1'b0;
      pin_b_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_oe <= 1'b0;
    end else begin
      pin_a_out <= connected[0] ? oc_d[0] : port_data_a;
      pin_b_out <= connected[1] ? oc_d[1] : port_data_b;
      pin_a_oe <= dir_q[0];
      pin_b_oe <= dir_q[1];
    end
  end

  // flag outputs for the interrupt logic next door
  assign wrap_flag = flags_q[0];
  assign match_flag_a = flags_q[1];
  assign match_flag_b = flags_q[2];

endmodule

// file: bench/tmw_pin_load.sv
// partner model: external load on the two compare pins
`timescale 1ns/1ns
module tmw_pin_load (
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  output logic pad_a,
  output logic pad_b
);
  // an undriven pad is pulled down, so a lost enable reads 0
  assign pad_a = pin_a_oe ? pin_a_out : 1'b0;
  assign pad_b = pin_b_oe ? pin_b_out : 1'b0;
endmodule

// file: bench/tmw_timer_props.sv
// checker: apb handshake, flag and pin assertions on the timer ports
`timescale 1ns/1ns
module tmw_timer_props
  import tmw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tick_enable,
  input wire logic port_data_a,
  input wire logic port_data_b,
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  input wire logic wrap_flag,
  input wire logic match_flag_a,
  input wire logic match_flag_b
);
  logic acc; // completed apb access
  logic [1:0] act_a_q; // snooped channel a action
  logic dir_a_q; // snooped direction bit a
  assign acc = psel && penable && pready;
  // snoop register writes so pin checks know the settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_a_q <= 2'h0;
      dir_a_q <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == TMW_CTRL_A_ADDR) act_a_q <= pwdata[7:6];
      if (paddr == TMW_DIR_ADDR) dir_a_q <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("pready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata)) else $error("read data moved");
  a_ctrl_rsvd_zero: assert property (acc && !pwrite &&
    paddr == TMW_CTRL_A_ADDR |-> prdata[3:2] == 2'h0)
    else $error("reserved control bits nonzero");
  a_wrap_needs_tick: assert property ($rose(wrap_flag)
    |-> $past(tick_enable)) else $error("wrap flag without tick");
  a_match_needs_tick: assert property ($rose(match_flag_a)
    || $rose(match_flag_b) |-> $past(tick_enable))
    else $error("match flag without tick");
  a_match_sticky: assert property (match_flag_a && !(acc &&
    pwrite && paddr == TMW_FLAGS_ADDR && pwdata[1]) |=> match_flag_a)
    else $error("match flag a lost");
  a_port_when_off: assert property (act_a_q == 2'h0 &&
    !(acc && pwrite) |=> pin_a_out == $past(port_data_a))
    else $error("pin a not port data");
  a_oe_follows_dir: assert property (acc && pwrite &&
    paddr == TMW_DIR_ADDR |-> ##[1:2] pin_a_oe == dir_a_q)
    else $error("pin a enable wrong");
  c_wrap: cover property ($rose(wrap_flag));
  c_match: cover property ($rose(match_flag_a));
  c_refused: cover property (pslverr);
endmodule
bind tmw_timer tmw_timer_props tmw_timer_props_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .tick_enable, .port_data_a, .port_data_b, .pin_a_out, .pin_a_oe,
  .pin_b_out, .pin_b_oe, .wrap_flag, .match_flag_a, .match_flag_b);

// file: bench/tmw_timer_bench.sv
// testbench: apb register tests and waveform scenarios of the timer
`timescale 1ns/1ns
module tmw_timer_bench
  import tmw_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic tick_enable = 0, port_data_a = 0, port_data_b = 0;
  logic pready, pslverr, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  logic wrap_flag, match_flag_a, match_flag_b, pad_a, pad_b;
  logic [7:0] rv; // last read byte
  logic re; // last response error
  int n_errors = 0, num_checks = 0, cyc = 0;
  always #50 pclk = ~pclk;
  tmw_timer tmw_timer_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tick_enable,
    .port_data_a, .port_data_b, .pin_a_out, .pin_a_oe, .pin_b_out,
    .pin_b_oe, .wrap_flag, .match_flag_a, .match_flag_b);
  tmw_pin_load tmw_pin_load_i (.pin_a_out, .pin_a_oe, .pin_b_out,
    .pin_b_oe, .pad_a, .pad_b);
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard: the whole run needs far fewer cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict;
    end
  end
  // one apb transfer; waits on pready, takes data at that edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata[7:0];
    re = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // n single-cycle ticks, then let pins settle
  task tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      tick_enable <= 1;
      @(posedge pclk);
      tick_enable <= 0;
    end
    repeat (2) @(posedge pclk);
  endtask
  task t_regs;
    apb(0, TMW_CTRL_A_ADDR, 0);
    chk(rv, TMW_CTRL_A_RST);
    apb(1, TMW_CTRL_A_ADDR, 8'hff);
    apb(0, TMW_CTRL_A_ADDR, 0);
    chk(rv, TMW_CTRL_A_MASK);
    apb(0, 8'h40, 0);
    chk({7'h0, re}, 8'h01);
    apb(1, TMW_CTRL_A_ADDR, 8'h00);
    $display("test regs done");
  endtask
  task t_normal;
    apb(1, TMW_COUNT_ADDR, 8'hfe);
    apb(1, TMW_FLAGS_ADDR, 8'h07);
    apb(0, TMW_COUNT_ADDR, 0);
    chk(rv, 8'hfe);
    tick(2);
    apb(0, TMW_COUNT_ADDR, 0);
    chk(rv, TMW_BOTTOM);
    chk({7'h0, wrap_flag}, 8'h01);
    $display("test normal done");
  endtask
  // set, clear, toggle on match, then disconnected
  task t_ctc;
    apb(1, TMW_CMP_A_ADDR, 8'h02);
    for (int i = 3; i > 0; i--) begin
      apb(1, TMW_CTRL_A_ADDR, {i[1:0], 6'h02});
      apb(1, TMW_COUNT_ADDR, 8'h00);
      apb(1, TMW_FLAGS_ADDR, 8'h07);
      tick(3);
      chk({7'h0, pad_a}, {7'h0, i != 2});
      chk({7'h0, match_flag_a}, 8'h01);
      apb(0, TMW_COUNT_ADDR, 0);
      chk(rv, 8'h00);
    end
    apb(1, TMW_CTRL_A_ADDR, 8'h02);
    port_data_a <= 1;
    tick(1);
    chk({7'h0, pad_a}, 8'h01);
    apb(1, TMW_DIR_ADDR, 8'h00);
    // the enable is registered, give it an edge to follow
    repeat (2) @(posedge pclk);
    chk({7'h0, pad_a}, 8'h00);
    apb(1, TMW_DIR_ADDR, 8'h03);
    port_data_a <= 0;
    $display("test ctc done");
  endtask
  task t_fast;
    apb(1, TMW_CMP_A_ADDR, 8'h10);
    apb(1, TMW_CTRL_A_ADDR, 8'h83);
    apb(1, TMW_COUNT_ADDR, 8'h0e);
    tick(3);
    chk({7'h0, pad_a}, 8'h00);
    apb(1, TMW_COUNT_ADDR, 8'hfd);
    apb(1, TMW_FLAGS_ADDR, 8'h07);
    tick(3);
    chk({7'h0, pad_a}, 8'h01);
    chk({7'h0, wrap_flag}, 8'h01);
    apb(0, TMW_COUNT_ADDR, 0);
    chk(rv, TMW_BOTTOM);
    // new compare waits for bottom, so no match at 5 yet
    apb(1, TMW_CMP_A_ADDR, 8'h05);
    apb(1, TMW_COUNT_ADDR, 8'h03);
    tick(3);
    chk({7'h0, pad_a}, 8'h01);
    $display("test fast done");
  endtask
  task t_phase;
    apb(1, TMW_CTRL_A_ADDR, 8'h00);
    apb(1, TMW_CMP_B_ADDR, 8'h05);
    apb(1, TMW_CTRL_A_ADDR, 8'h21);
    apb(1, TMW_COUNT_ADDR, 8'hfe);
    tick(2);
    apb(0, TMW_COUNT_ADDR, 0);
    chk(rv, 8'hfe);
    apb(1, TMW_COUNT_ADDR, 8'h06);
    tick(3);
    chk({7'h0, pad_b}, 8'h01);
    chk({7'h0, match_flag_b}, 8'h01);
    apb(1, TMW_FLAGS_ADDR, 8'h07);
    tick(4);
    chk({7'h0, wrap_flag}, 8'h01);
    apb(1, TMW_COUNT_ADDR, 8'h03);
    tick(3);
    chk({7'h0, pad_b}, 8'h00);
    $display("test phase done");
  endtask
  task t_reserved;
    port_data_a <= 1;
    port_data_b <= 1;
    apb(1, TMW_CTRL_B_ADDR, 8'h01);
    apb(1, TMW_CTRL_A_ADDR, 8'h60);
    apb(1, TMW_COUNT_ADDR, 8'h40);
    tick(3);
    apb(0, TMW_COUNT_ADDR, 0);
    chk(rv, 8'h40);
    chk({6'h0, pad_a, pad_b}, 8'h03);
    apb(1, TMW_CTRL_B_ADDR, 8'h00);
    apb(1, TMW_CTRL_A_ADDR, 8'h53);
    tick(1);
    chk({7'h0, pad_a}, 8'h01);
    chk({7'h0, pad_b}, 8'h01);
    $display("test reserved done");
  endtask
  // compare a as top: fast ignores the match, phase acts at top
  task t_top;
    apb(1, TMW_CTRL_A_ADDR, 8'h00);
    apb(1, TMW_CMP_A_ADDR, 8'h08);
    apb(1, TMW_CTRL_B_ADDR, 8'h01);
    apb(1, TMW_CTRL_A_ADDR, 8'hc3);
    apb(1, TMW_COUNT_ADDR, 8'h06);
    apb(1, TMW_FLAGS_ADDR, 8'h07);
    tick(3);
    chk({7'h0, pad_a}, 8'h00);
    chk({7'h0, match_flag_a}, 8'h01);
    chk({7'h0, wrap_flag}, 8'h01);
    apb(0, TMW_COUNT_ADDR, 0);
    chk(rv, TMW_BOTTOM);
    apb(1, TMW_CTRL_A_ADDR, 8'h81);
    apb(1, TMW_COUNT_ADDR, 8'h06);
    tick(3);
    chk({7'h0, pad_a}, 8'h01);
    apb(0, TMW_COUNT_ADDR, 0);
    chk(rv, 8'h07);
    $display("test top done");
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_regs;
    apb(1, TMW_DIR_ADDR, 8'h03);
    t_normal;
    t_ctc;
    t_fast;
    t_phase;
    t_reserved;
    t_top;
    print_verdict;
  end
endmodule
